// *** logic/rtk_cfg.svh ***
// Constants for the RTC trim, key and pin configuration block.
// Included by the design and testbench files by bare name.
`ifndef RTK_CFG_SVH
`define RTK_CFG_SVH

// Special function register addresses
`define RTK_ADR_TIMER_CFG 8'hA1
`define RTK_ADR_FRAC      8'hA2
`define RTK_ADR_SEC       8'hA3
`define RTK_ADR_MIN       8'hA4
`define RTK_ADR_HOUR      8'hA5
`define RTK_ADR_INTERVAL  8'hA6
`define RTK_ADR_KEY       8'hC1
`define RTK_ADR_PWR_CTL   8'hC5
`define RTK_ADR_NOM_TRIM  8'hF6
`define RTK_ADR_THERM     8'hF7
`define RTK_ADR_PIN_CFG   8'hFF

// Key values
`define RTK_KEY_PWR       8'hA7
`define RTK_KEY_CNT       8'hEA

// Reset values
`define RTK_RST_BYTE      8'h00
`define RTK_RST_TIMER_CFG 8'h01

// Field positions
`define RTK_CAL_EN_BIT    7
`define RTK_FSEL_MSB      6
`define RTK_FSEL_LSB      5
`define RTK_IRQ1_MSB      3
`define RTK_IRQ1_LSB      1
`define RTK_IRQ0_BIT      0
`define RTK_PIN_CFG_MASK  8'hEF
`define RTK_TFH_BIT       6

// Counter wrap points
`define RTK_FRAC_MAX      8'h7F
`define RTK_SEC_MAX       8'h3B
`define RTK_MIN_MAX       8'h3B
`define RTK_HOUR24_MAX    8'h17
`define RTK_HOUR256_MAX   8'hFF

// Timebase: prescale step in fast mode, 128 Hz carry bit, output taps
`define RTK_FAST_STEP     15'h007D
`define RTK_TICK128_BIT   8
`define RTK_CAL_1HZ_BIT   14
`define RTK_CAL_512_BIT   5
`define RTK_CAL_500_BIT   12

// Compensation: 2 ppm per LSB, clamp at 248 ppm
`define RTK_PPM_PER_LSB   20'h00002
`define RTK_PPM_FULL      20'hF4240
`define RTK_TRIM_LIMIT    9'h07C

`endif

// *** logic/rtk_pkg.sv ***
// Types shared by the RTC trim and key block.
// No state; constants live in rtk_cfg.svh.
package rtk_pkg;

  typedef enum logic [2:0] {
    step_skip = 3'b001,
    step_one  = 3'b010,
    step_two  = 3'b100
  } rtk_step_t;

  typedef enum logic [1:0] {
    fsel_1hz   = 2'b00,
    fsel_512hz = 2'b01,
    fsel_500hz = 2'b10,
    fsel_16khz = 2'b11
  } rtk_fsel_t;

endpackage : rtk_pkg

// *** logic/rtk_top.sv ***
// RTC trim registers, calibration output, pin config and unlock key.
// Assumes a single-cycle SFR bus from the core on i_clk_sys; the crystal
// and interrupt pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ns
`include "rtk_cfg.svh"
module rtk_top
  import rtk_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_srst,
  input  wire logic       i_wdt_rst,
  input  wire logic       i_ext_rst,
  // SFR bus
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  // Pins
  input  wire logic       i_xtal_32k,
  input  wire logic       i_ext_irq_zero,
  input  wire logic       i_ext_irq_one,
  output logic            o_cal_pin_out,
  output logic            o_cal_pin_oe_n,
  // Pin function and gated interrupts
  output logic            o_ext_irq_zero_req,
  output logic            o_ext_irq_one_req,
  output logic            o_irq1_gpio_sel,
  output logic            o_irq1_battery_ctrl_input_sel,
  // Power control
  output logic      [7:0] o_power_control_reg,
  output logic            o_power_control_wr
);

  rtk_trim_if trim_bus ();

  rtk_trim u_trim (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .trim_bus  (trim_bus.trim)
  );

  function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] top);
    wrap_inc = (v == top) ? 8'h00 : v + 8'h01;
  endfunction : wrap_inc

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = i_sfr_wr && (i_sfr_addr == a);
  endfunction : wr_at

  // Pin synchronisers
  logic [2:0] xtal_sync_q;
  logic [2:0] xtal_sync_d;
  logic [1:0] irq0_sync_q;
  logic [1:0] irq0_sync_d;
  logic [1:0] irq1_sync_q;
  logic [1:0] irq1_sync_d;

  always_comb begin
    xtal_sync_d = {xtal_sync_q[1:0], i_xtal_32k};
    irq0_sync_d = {irq0_sync_q[0], i_ext_irq_zero};
    irq1_sync_d = {irq1_sync_q[0], i_ext_irq_one};
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      xtal_sync_q <= 3'h0;
      irq0_sync_q <= 2'h0;
      irq1_sync_q <= 2'h0;
    end else begin
      xtal_sync_q <= xtal_sync_d;
      irq0_sync_q <= irq0_sync_d;
      irq1_sync_q <= irq1_sync_d;
    end
  end

  // Edge taken after the second stage only
  logic xtal_tick;
  assign xtal_tick = xtal_sync_q[1] & ~xtal_sync_q[2];

  // Trim, key, pin and power registers
  logic [7:0] nom_trim_q;
  logic [7:0] nom_trim_d;
  logic [7:0] therm_trim_q;
  logic [7:0] therm_trim_d;
  logic [7:0] key_q;
  logic [7:0] key_d;
  logic [7:0] pin_cfg_q;
  logic [7:0] pin_cfg_d;
  logic [7:0] pwr_q;
  logic [7:0] pwr_d;
  logic       pwr_wr_q;
  logic       pwr_wr_d;
  logic       trim_clr;
  logic       cnt_wr;
  logic       cnt_ok;

  always_comb begin
    trim_clr     = i_wdt_rst | i_ext_rst;
    cnt_wr       = wr_at(`RTK_ADR_FRAC) | wr_at(`RTK_ADR_SEC)
                 | wr_at(`RTK_ADR_MIN)  | wr_at(`RTK_ADR_HOUR);
    cnt_ok       = cnt_wr && (key_q == `RTK_KEY_CNT);
    nom_trim_d   = nom_trim_q;
    therm_trim_d = therm_trim_q;
    key_d        = key_q;
    pin_cfg_d    = pin_cfg_q;
    pwr_d        = pwr_q;
    pwr_wr_d     = 1'b0;
    if (wr_at(`RTK_ADR_NOM_TRIM)) begin
      nom_trim_d = i_sfr_wdata;
    end
    if (wr_at(`RTK_ADR_THERM)) begin
      therm_trim_d = i_sfr_wdata;
    end
    if (trim_clr) begin
      nom_trim_d   = `RTK_RST_BYTE;
      therm_trim_d = `RTK_RST_BYTE;
    end
    if (wr_at(`RTK_ADR_KEY)) begin
      key_d = i_sfr_wdata;
    end
    // A counter write always burns the key, so a stray write cannot reuse it
    if (cnt_wr) begin
      key_d = `RTK_RST_BYTE;
    end
    if (wr_at(`RTK_ADR_PIN_CFG)) begin
      pin_cfg_d = i_sfr_wdata & `RTK_PIN_CFG_MASK;
    end
    if (wr_at(`RTK_ADR_PWR_CTL) && (key_q == `RTK_KEY_PWR)) begin
      pwr_d    = i_sfr_wdata;
      pwr_wr_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      nom_trim_q   <= `RTK_RST_BYTE;
      therm_trim_q <= `RTK_RST_BYTE;
      key_q        <= `RTK_RST_BYTE;
      pin_cfg_q    <= `RTK_RST_BYTE;
      pwr_q        <= `RTK_RST_BYTE;
      pwr_wr_q     <= 1'b0;
    end else begin
      nom_trim_q   <= nom_trim_d;
      therm_trim_q <= therm_trim_d;
      key_q        <= key_d;
      pin_cfg_q    <= pin_cfg_d;
      pwr_q        <= pwr_d;
      pwr_wr_q     <= pwr_wr_d;
    end
  end

  assign trim_bus.nominal   = nom_trim_q;
  assign trim_bus.thermal   = therm_trim_q;
  assign trim_bus.xtal_tick = xtal_tick;

  // Calibrated timebase
  rtk_fsel_t  fsel;
  logic       fast_mode;
  logic [14:0] pre_q;
  logic [14:0] pre_d;
  logic [14:0] pre_inc;
  logic       half_q;
  logic       half_d;
  logic       tick128;

  always_comb begin
    fsel      = rtk_fsel_t'(pin_cfg_q[`RTK_FSEL_MSB:`RTK_FSEL_LSB]);
    fast_mode = pin_cfg_q[`RTK_FSEL_MSB];
    case (trim_bus.step)
      step_skip: pre_inc = 15'h0000;
      step_one:  pre_inc = fast_mode ? `RTK_FAST_STEP : 15'h0001;
      step_two:  pre_inc = fast_mode ? 15'(`RTK_FAST_STEP * 2) : 15'h0002;
      default:   pre_inc = 15'h0001;
    endcase
    pre_d  = pre_q;
    half_d = half_q;
    if (xtal_tick) begin
      pre_d  = pre_q + pre_inc;
      half_d = half_q ^ (trim_bus.step != step_skip);
    end
    tick128 = (pre_d[14:`RTK_TICK128_BIT] != pre_q[14:`RTK_TICK128_BIT]);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pre_q  <= 15'h0000;
      half_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      half_q <= half_d;
    end
  end

  // Config and interval staged, applied on the 128 Hz tick
  logic [7:0] tcfg_q;
  logic [7:0] tcfg_d;
  logic [7:0] tcfg_stg_q;
  logic [7:0] tcfg_stg_d;
  logic       tcfg_pend_q;
  logic       tcfg_pend_d;
  logic [7:0] ival_q;
  logic [7:0] ival_d;
  logic [7:0] ival_stg_q;
  logic [7:0] ival_stg_d;
  logic       ival_pend_q;
  logic       ival_pend_d;

  always_comb begin
    tcfg_d      = tcfg_q;
    tcfg_stg_d  = tcfg_stg_q;
    tcfg_pend_d = tcfg_pend_q;
    ival_d      = ival_q;
    ival_stg_d  = ival_stg_q;
    ival_pend_d = ival_pend_q;
    if (tick128 && tcfg_pend_q) begin
      tcfg_d      = tcfg_stg_q;
      tcfg_pend_d = 1'b0;
    end
    if (tick128 && ival_pend_q) begin
      ival_d      = ival_stg_q;
      ival_pend_d = 1'b0;
    end
    // A fresh write stays pending past the apply in the same cycle, which still takes the older staged value
    if (wr_at(`RTK_ADR_TIMER_CFG)) begin
      tcfg_stg_d  = i_sfr_wdata;
      tcfg_pend_d = 1'b1;
    end
    if (wr_at(`RTK_ADR_INTERVAL)) begin
      ival_stg_d  = i_sfr_wdata;
      ival_pend_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tcfg_q      <= `RTK_RST_TIMER_CFG;
      tcfg_stg_q  <= `RTK_RST_TIMER_CFG;
      tcfg_pend_q <= 1'b0;
      ival_q      <= `RTK_RST_BYTE;
      ival_stg_q  <= `RTK_RST_BYTE;
      ival_pend_q <= 1'b0;
    end else begin
      tcfg_q      <= tcfg_d;
      tcfg_stg_q  <= tcfg_stg_d;
      tcfg_pend_q <= tcfg_pend_d;
      ival_q      <= ival_d;
      ival_stg_q  <= ival_stg_d;
      ival_pend_q <= ival_pend_d;
    end
  end

  // Timekeeping counters; only power-on reset clears them
  logic [7:0] frac_tick_tally_q;
  logic [7:0] frac_tick_tally_d;
  logic [7:0] one_hz_tally_q;
  logic [7:0] one_hz_tally_d;
  logic [7:0] min_q;
  logic [7:0] min_d;
  logic [7:0] hour_q;
  logic [7:0] hour_d;
  logic [7:0] hour_top;

  always_comb begin
    hour_top = tcfg_q[`RTK_TFH_BIT] ? `RTK_HOUR24_MAX : `RTK_HOUR256_MAX;
    frac_tick_tally_d = frac_tick_tally_q;
    one_hz_tally_d    = one_hz_tally_q;
    min_d             = min_q;
    hour_d            = hour_q;
    if (tick128) begin
      frac_tick_tally_d = wrap_inc(frac_tick_tally_q, `RTK_FRAC_MAX);
      if (frac_tick_tally_q == `RTK_FRAC_MAX) begin
        one_hz_tally_d = wrap_inc(one_hz_tally_q, `RTK_SEC_MAX);
        if (one_hz_tally_q == `RTK_SEC_MAX) begin
          min_d = wrap_inc(min_q, `RTK_MIN_MAX);
          if (min_q == `RTK_MIN_MAX) begin
            hour_d = wrap_inc(hour_q, hour_top);
          end
        end
      end
    end
    // Software load beats the tick it collides with
    if (cnt_ok && (i_sfr_addr == `RTK_ADR_FRAC)) begin
      frac_tick_tally_d = i_sfr_wdata;
    end
    if (cnt_ok && (i_sfr_addr == `RTK_ADR_SEC)) begin
      one_hz_tally_d = i_sfr_wdata;
    end
    if (cnt_ok && (i_sfr_addr == `RTK_ADR_MIN)) begin
      min_d = i_sfr_wdata;
    end
    if (cnt_ok && (i_sfr_addr == `RTK_ADR_HOUR)) begin
      hour_d = i_sfr_wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      frac_tick_tally_q <= `RTK_RST_BYTE;
      one_hz_tally_q    <= `RTK_RST_BYTE;
      min_q             <= `RTK_RST_BYTE;
      hour_q            <= `RTK_RST_BYTE;
    end else begin
      frac_tick_tally_q <= frac_tick_tally_d;
      one_hz_tally_q    <= one_hz_tally_d;
      min_q             <= min_d;
      hour_q            <= hour_d;
    end
  end

  // Output pins and read data
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       cal_q;
  logic       cal_d;
  logic       cal_oe_n_q;
  logic       cal_oe_n_d;
  logic       irq0_q;
  logic       irq0_d;
  logic       irq1_q;
  logic       irq1_d;
  logic       gpio_q;
  logic       gpio_d;
  logic       battery_ctrl_input_q;
  logic       battery_ctrl_input_d;
  logic [2:0] irq1_cfg;

  always_comb begin
    irq1_cfg = pin_cfg_q[`RTK_IRQ1_MSB:`RTK_IRQ1_LSB];
    case (fsel)
      fsel_1hz:   cal_d = pre_q[`RTK_CAL_1HZ_BIT];
      fsel_512hz: cal_d = pre_q[`RTK_CAL_512_BIT];
      fsel_500hz: cal_d = pre_q[`RTK_CAL_500_BIT];
      fsel_16khz: cal_d = half_q;
      default:    cal_d = 1'b0;
    endcase
    cal_d      = cal_d & pin_cfg_q[`RTK_CAL_EN_BIT];
    cal_oe_n_d = ~pin_cfg_q[`RTK_CAL_EN_BIT];
    gpio_d     = (irq1_cfg[1:0] == 2'h0);
    battery_ctrl_input_d    = (irq1_cfg[1:0] == 2'h1);
    irq1_d     = (irq1_cfg[2:1] == 2'h3) & irq1_sync_q[1];
    irq0_d     = pin_cfg_q[`RTK_IRQ0_BIT] & irq0_sync_q[1];
    rdata_d    = rdata_q;
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        `RTK_ADR_TIMER_CFG: rdata_d = tcfg_q;
        `RTK_ADR_FRAC:      rdata_d = frac_tick_tally_q;
        `RTK_ADR_SEC:       rdata_d = one_hz_tally_q;
        `RTK_ADR_MIN:       rdata_d = min_q;
        `RTK_ADR_HOUR:      rdata_d = hour_q;
        `RTK_ADR_INTERVAL:  rdata_d = ival_q;
        `RTK_ADR_KEY:       rdata_d = key_q;
        `RTK_ADR_PWR_CTL:   rdata_d = pwr_q;
        `RTK_ADR_NOM_TRIM:  rdata_d = nom_trim_q;
        `RTK_ADR_THERM:     rdata_d = therm_trim_q;
        `RTK_ADR_PIN_CFG:   rdata_d = pin_cfg_q;
        default:            rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rdata_q    <= 8'h00;
      cal_q      <= 1'b0;
      cal_oe_n_q <= 1'b1;
      irq0_q     <= 1'b0;
      irq1_q     <= 1'b0;
      gpio_q     <= 1'b1;
      battery_ctrl_input_q    <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      cal_q      <= cal_d;
      cal_oe_n_q <= cal_oe_n_d;
      irq0_q     <= irq0_d;
      irq1_q     <= irq1_d;
      gpio_q     <= gpio_d;
      battery_ctrl_input_q    <= battery_ctrl_input_d;
    end
  end

  assign o_sfr_rdata         = rdata_q;
  assign o_cal_pin_out       = cal_q;
  assign o_cal_pin_oe_n      = cal_oe_n_q;
  assign o_ext_irq_zero_req  = irq0_q;
  assign o_ext_irq_one_req   = irq1_q;
  assign o_irq1_gpio_sel     = gpio_q;
  assign o_irq1_battery_ctrl_input_sel    = battery_ctrl_input_q;
  assign o_power_control_reg = pwr_q;
  assign o_power_control_wr  = pwr_wr_q;

endmodule : rtk_top

// *** logic/rtk_trim.sv ***
// Crystal compensation engine: sums both trims and adds or drops ticks.
// Assumes xtal_tick is a one-cycle pulse per crystal period.
`timescale 1ns/1ns
`include "rtk_cfg.svh"
module rtk_trim
  import rtk_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // Trim channel
  rtk_trim_if.trim  trim_bus
);

  logic [19:0] ppm_acc_q;
  logic [19:0] ppm_acc_d;
  logic [8:0]  sum;
  logic [8:0]  clamped;
  logic [8:0]  mag;
  logic [19:0] add;
  logic        neg;

  function automatic logic [8:0] sext8(input logic [7:0] v);
    sext8 = {v[7], v};
  endfunction : sext8

  always_comb begin
    sum = sext8(trim_bus.nominal) + sext8(trim_bus.thermal);
    if ($signed(sum) > $signed(`RTK_TRIM_LIMIT)) begin
      clamped = `RTK_TRIM_LIMIT;
    end else if ($signed(sum) < -$signed(`RTK_TRIM_LIMIT)) begin
      clamped = 9'(-`RTK_TRIM_LIMIT);
    end else begin
      clamped = sum;
    end
    neg = clamped[8];
    mag = neg ? 9'(-clamped) : clamped;
    add = 20'(mag) * `RTK_PPM_PER_LSB;
    ppm_acc_d = ppm_acc_q;
    trim_bus.step = step_one;
    if (trim_bus.xtal_tick) begin
      // Accumulate error in ppm; one whole tick is due per million
      if (ppm_acc_q + add >= `RTK_PPM_FULL) begin
        ppm_acc_d = ppm_acc_q + add - `RTK_PPM_FULL;
        trim_bus.step = neg ? step_skip : step_two;
      end else begin
        ppm_acc_d = ppm_acc_q + add;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      ppm_acc_q <= 20'h00000;
    end else begin
      ppm_acc_q <= ppm_acc_d;
    end
  end

endmodule : rtk_trim

// *** logic/rtk_trim_if.sv ***
// Carrier between the core register logic and the trim engine.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface rtk_trim_if;
  import rtk_pkg::*;

  logic [7:0] nominal;
  logic [7:0] thermal;
  logic       xtal_tick;
  rtk_step_t  step;

  modport core (output nominal, output thermal, output xtal_tick, input step);
  modport trim (input nominal, input thermal, input xtal_tick, output step);
endinterface : rtk_trim_if

// *** tb/rtk_core_model.sv ***
// Core-side SFR master model with single-cycle strobes.
// Assumes the block samples strobes on the rising clock edge.
`timescale 1ns/1ns
`include "rtk_cfg.svh"
module rtk_core_model
  import rtk_pkg::*;
(
  // Clock
  input  wire logic       i_clk_sys,
  // SFR bus
  output logic      [7:0] o_sfr_addr,
  output logic      [7:0] o_sfr_wdata,
  output logic            o_sfr_wr,
  output logic            o_sfr_rd,
  input  wire logic [7:0] i_sfr_rdata
);
  initial begin
    o_sfr_addr  = 8'h00;
    o_sfr_wdata = 8'h00;
    o_sfr_wr    = 1'b0;
    o_sfr_rd    = 1'b0;
  end
  // Idle bus shows inverted values, so stale data never passes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    o_sfr_addr  <= a;
    o_sfr_wdata <= d;
    o_sfr_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_sfr_wr    <= 1'b0;
    o_sfr_addr  <= ~a;
    o_sfr_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    o_sfr_addr <= a;
    o_sfr_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_sfr_rd   <= 1'b0;
    o_sfr_addr <= ~a;
    #1;
    v = i_sfr_rdata;
  endtask : rd
  // Key first, then the guarded write
  task automatic unlock_wr(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
    wr(`RTK_ADR_KEY, k);
    wr(a, d);
  endtask : unlock_wr
endmodule : rtk_core_model

// *** tb/rtk_top_checker.sv ***
// Assertion checker for rtk_top, bound to its ports by name.
// Assumes single-cycle SFR strobes sampled on i_clk_sys.
`timescale 1ns/1ns
`include "rtk_cfg.svh"
module rtk_top_checker
  import rtk_pkg::*;
(
  // Clock and resets
  input wire logic       i_clk_sys,
  input wire logic       i_srst,
  input wire logic       i_wdt_rst,
  input wire logic       i_ext_rst,
  // SFR bus
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  // Watched outputs
  input wire logic       o_cal_pin_out,
  input wire logic       o_cal_pin_oe_n,
  input wire logic       o_ext_irq_zero_req,
  input wire logic       o_ext_irq_one_req,
  input wire logic       o_irq1_gpio_sel,
  input wire logic       o_irq1_battery_ctrl_input_sel,
  input wire logic [7:0] o_power_control_reg,
  input wire logic       o_power_control_wr
);
  logic [7:0] key_q, key_d, cfg_q, cfg_d, cfg_p_q;
  logic       trim0_q, trim0_d, st, rd_ok, pwr_ok;
  // Mirror of key, pin config and cleared trim
  always_comb begin
    key_d   = key_q;
    cfg_d   = cfg_q;
    trim0_d = trim0_q;
    if (i_sfr_wr && i_sfr_addr == `RTK_ADR_KEY) key_d = i_sfr_wdata;
    if (i_sfr_wr && i_sfr_addr inside {[`RTK_ADR_FRAC:`RTK_ADR_HOUR]}) key_d = 8'h00;
    if (i_sfr_wr && i_sfr_addr == `RTK_ADR_PIN_CFG) cfg_d = i_sfr_wdata & `RTK_PIN_CFG_MASK;
    if (i_sfr_wr && i_sfr_addr == `RTK_ADR_NOM_TRIM) trim0_d = 1'b0;
    if (i_wdt_rst || i_ext_rst) trim0_d = 1'b1;
    if (i_srst) begin
      key_d   = 8'h00;
      cfg_d   = 8'h00;
      trim0_d = 1'b1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    key_q   <= key_d;
    cfg_q   <= cfg_d;
    cfg_p_q <= cfg_q;
    trim0_q <= trim0_d;
  end
  // Pin config outputs are only judged once config has settled a cycle
  assign st     = (cfg_q == cfg_p_q);
  assign rd_ok  = i_sfr_rd && !i_sfr_wr;
  assign pwr_ok = i_sfr_wr && i_sfr_addr == `RTK_ADR_PWR_CTL && key_q == `RTK_KEY_PWR;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  AST_PWR_ACCEPT: assert property (pwr_ok |=> o_power_control_wr
    && o_power_control_reg == $past(i_sfr_wdata)) else $error("power write lost");
  AST_PWR_ONLY_KEYED: assert property (o_power_control_wr |-> $past(pwr_ok))
    else $error("power pulse without key");
  AST_KEY_READ: assert property (rd_ok && i_sfr_addr == `RTK_ADR_KEY |=>
    o_sfr_rdata == key_q) else $error("key readback wrong");
  AST_TRIM_CLEAR: assert property (rd_ok && trim0_q && i_sfr_addr == `RTK_ADR_NOM_TRIM
    |=> o_sfr_rdata == 8'h00) else $error("trim not cleared");
  AST_OE_EN: assert property (st |-> o_cal_pin_oe_n == !cfg_q[7])
    else $error("cal enable mismatch");
  AST_CAL_IDLE: assert property (st && !cfg_q[7] |-> !o_cal_pin_out)
    else $error("cal pin active while off");
  AST_IRQ1_SEL: assert property (st |-> o_irq1_gpio_sel == (cfg_q[2:1] == 2'b00)
    && o_irq1_battery_ctrl_input_sel == (cfg_q[2:1] == 2'b01)) else $error("irq1 function wrong");
  AST_IRQ0_GATE: assert property (st && !cfg_q[0] |-> !o_ext_irq_zero_req)
    else $error("irq0 not gated");
  AST_IRQ1_GATE: assert property (st && cfg_q[3:2] != 2'b11 |-> !o_ext_irq_one_req)
    else $error("irq1 not gated");

  cover property (pwr_ok);
  cover property (i_sfr_wr && i_sfr_addr == `RTK_ADR_SEC && key_q == `RTK_KEY_CNT);
  cover property (st && cfg_q[7] && cfg_q[6:5] == 2'b11);
endmodule : rtk_top_checker

bind rtk_top rtk_top_checker i_rtk_top_checker (.i_clk_sys, .i_srst, .i_wdt_rst, .i_ext_rst,
  .i_sfr_addr, .i_sfr_wdata, .i_sfr_wr, .i_sfr_rd, .o_sfr_rdata, .o_cal_pin_out,
  .o_cal_pin_oe_n, .o_ext_irq_zero_req, .o_ext_irq_one_req, .o_irq1_gpio_sel,
  .o_irq1_battery_ctrl_input_sel, .o_power_control_reg, .o_power_control_wr);

// *** tb/tb.sv ***
// Self-checking bench for rtk_top: register table, then reset,
// key, power, pin and calibration tests. Crystal runs free.
`timescale 1ns/1ns
`include "rtk_cfg.svh"
module tb
  import rtk_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} rtk_row_t;
  logic       clk_sys = 1'b0;
  logic       srst    = 1'b1;
  logic       wdt_rst = 1'b0;
  logic       ext_rst = 1'b0;
  logic       xtal    = 1'b0;
  logic       irq0    = 1'b0;
  logic       irq1    = 1'b0;
  logic [7:0] addr, wdata, rdata, pwr, v;
  logic       wr, rd, cal, oe_n, rq0, rq1, gsel, bsel, pwr_wr;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         n;
  int         cal_half [2] = '{763, 24414};
  logic [1:0] cal_sel  [2] = '{2'b11, 2'b01};
  rtk_row_t   rows     [5] = '{'{8'hF6, 8'h5A, 8'h5A}, '{8'hF7, 8'h83, 8'h83},
                               '{8'hFF, 8'h1F, 8'h0F}, '{8'hC1, 8'h3C, 8'h3C},
                               '{8'h10, 8'h55, 8'h00}};
  always #20 clk_sys = ~clk_sys;
  always #15259 xtal = ~xtal;

  rtk_top i_rtk_top (.i_clk_sys(clk_sys), .i_srst(srst), .i_wdt_rst(wdt_rst),
    .i_ext_rst(ext_rst), .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_xtal_32k(xtal), .i_ext_irq_zero(irq0),
    .i_ext_irq_one(irq1), .o_cal_pin_out(cal), .o_cal_pin_oe_n(oe_n),
    .o_ext_irq_zero_req(rq0), .o_ext_irq_one_req(rq1), .o_irq1_gpio_sel(gsel),
    .o_irq1_battery_ctrl_input_sel(bsel), .o_power_control_reg(pwr), .o_power_control_wr(pwr_wr));
  rtk_core_model i_rtk_core_model (.i_clk_sys(clk_sys), .o_sfr_addr(addr),
    .o_sfr_wdata(wdata), .o_sfr_wr(wr), .o_sfr_rd(rd), .i_sfr_rdata(rdata));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s: got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string m);
    i_rtk_core_model.rd(a, v);
    chk(v, e, m);
  endtask : rdchk
  // Bounded wait for the next calibration pin change
  task automatic wait_edge(output int cnt);
    logic old;
    #1;
    old = cal;
    cnt = 0;
    while (cal === old) begin
      @(posedge clk_sys);
      #1;
      cnt++;
      if (cnt > 30000) begin
        miscompares++;
        $display("ERROR %0t cal pin stuck", $time);
        stop_test();
      end
    end
  endtask : wait_edge

  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    rdchk(`RTK_ADR_NOM_TRIM, 8'h00, "nominal reset");
    rdchk(`RTK_ADR_THERM, 8'h00, "thermal reset");
    rdchk(`RTK_ADR_KEY, 8'h00, "key reset");
    rdchk(`RTK_ADR_PIN_CFG, 8'h00, "pin reset");
    chk(8'(oe_n), 8'h01, "oe reset");
    $display("test reset done");
    foreach (rows[i]) begin
      i_rtk_core_model.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e, "row readback");
    end
    $display("test table done");
    for (int k = 0; k < 2; k++) begin
      i_rtk_core_model.wr(`RTK_ADR_NOM_TRIM, 8'h7F);
      i_rtk_core_model.wr(`RTK_ADR_THERM, 8'h80);
      @(posedge clk_sys);
      wdt_rst <= (k == 0);
      ext_rst <= (k == 1);
      @(posedge clk_sys);
      wdt_rst <= 1'b0;
      ext_rst <= 1'b0;
      rdchk(`RTK_ADR_NOM_TRIM, 8'h00, "nominal cleared");
      rdchk(`RTK_ADR_THERM, 8'h00, "thermal cleared");
      rdchk(`RTK_ADR_KEY, 8'h3C, "key kept");
    end
    $display("test trim reset done");
    for (int k = 0; k < 4; k++) begin
      i_rtk_core_model.unlock_wr(`RTK_KEY_CNT, 8'hA2 + 8'(k), 8'h10 + 8'(k));
      rdchk(8'hA2 + 8'(k), 8'h10 + 8'(k), "counter load");
      rdchk(`RTK_ADR_KEY, 8'h00, "key cleared");
    end
    i_rtk_core_model.wr(`RTK_ADR_SEC, 8'h05);
    rdchk(`RTK_ADR_SEC, 8'h11, "counter locked");
    i_rtk_core_model.unlock_wr(`RTK_KEY_PWR, `RTK_ADR_MIN, 8'h05);
    rdchk(`RTK_ADR_MIN, 8'h12, "counter wrong key");
    $display("test counter key done");
    i_rtk_core_model.unlock_wr(`RTK_KEY_PWR, `RTK_ADR_PWR_CTL, 8'h5A);
    #1;
    chk(8'(pwr_wr), 8'h01, "power pulse");
    chk(pwr, 8'h5A, "power value");
    i_rtk_core_model.unlock_wr(8'h00, `RTK_ADR_PWR_CTL, 8'hA5);
    repeat (2) @(posedge clk_sys);
    chk(pwr, 8'h5A, "power locked");
    $display("test power done");
    @(posedge clk_sys);
    irq0 <= 1'b1;
    irq1 <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      i_rtk_core_model.wr(`RTK_ADR_PIN_CFG, 8'(c));
      repeat (3) @(posedge clk_sys);
      #1;
      chk(8'(gsel), 8'(c[2:1] == 2'b00), "gpio select");
      chk(8'(bsel), 8'(c[2:1] == 2'b01), "battery select");
      chk(8'(rq1), 8'(c[3:2] == 2'b11), "irq1 gate");
      chk(8'(rq0), 8'(c[0]), "irq0 gate");
    end
    $display("test pin config done");
    for (int f = 0; f < 4; f++) begin
      i_rtk_core_model.wr(`RTK_ADR_PIN_CFG, {1'b1, 2'(f), 5'h00});
      repeat (2) @(posedge clk_sys);
      #1;
      chk(8'(oe_n), 8'h00, "cal driven");
    end
    // Fast mode gives a 128 Hz tick every two or three crystal ticks
    i_rtk_core_model.wr(`RTK_ADR_TIMER_CFG, 8'h41);
    i_rtk_core_model.wr(`RTK_ADR_INTERVAL, 8'h5C);
    n = 0;
    v = 8'h00;
    while (v !== 8'h5C && n < 1600) begin
      i_rtk_core_model.rd(`RTK_ADR_INTERVAL, v);
      n++;
    end
    chk(v, 8'h5C, "interval applied");
    if (v !== 8'h5C) begin
      stop_test();
    end
    rdchk(`RTK_ADR_TIMER_CFG, 8'h41, "config applied");
    $display("test staging done");
    foreach (cal_sel[j]) begin
      i_rtk_core_model.wr(`RTK_ADR_PIN_CFG, {1'b1, cal_sel[j], 5'h00});
      // First change may be the mode switch itself, so time the third
      wait_edge(n);
      wait_edge(n);
      wait_edge(n);
      chk(8'(n >= cal_half[j] - 4 && n <= cal_half[j] + 4), 8'h01, "cal period");
    end
    i_rtk_core_model.wr(`RTK_ADR_PIN_CFG, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    chk(8'(oe_n), 8'h01, "cal released");
    chk(8'(cal), 8'h00, "cal low");
    $display("test calibration done");
    stop_test();
  end
endmodule : tb
